// file: core/ram_host_defines.svh
// timing counts and field positions for the latched-address ram host
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - Host keeps write strobe high for the whole of a read.
// - Host may hold output enable high in writes; data setup/hold still met.
// - Host never lowers select and output enable before the write strobe.
// - If select rises first, data setup and hold reference the select rise.
// - Strobe may stay low across writes; data then references each select rise.
// - All selects high for the minimum high time before any select falls.
// - Every new address comes with a fresh select high-to-low transition.
// - Never more than one bank selected when data buses are tied.
// - Decoder address bits stay valid at least the decoder address valid time.
// - Wide mode drives both banks alike; byte mode drives each bank alone.
// - Select stays low at least 250 ns per cycle.
// - Select falling edges at least 350 ns apart.
// - Strobe low at least 140 ns, and 140 ns before select rises.
// - Strobe low at least 250 ns from select fall.
`ifndef RAM_HOST_DEFINES_SVH
`define RAM_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define ADDR_W 14
`define BANK_SEL_BIT 14
`define ADDR_SETUP_NS 20
`define MIN_SELECT_HIGH_TIME_NS 100
`define SELECT_LOW_NS 250
`define CYCLE_NS 350
`define STROBE_LOW_NS 140
`define STROBE_HOLD_NS 250
`define WRITE_DATA_SETUP_NS 20
`define WRITE_DATA_HOLD_NS 70
`define DECODER_ADDRESS_VALID_TIME_NS 270
`define ACCESS_NS 250
`define OUT_DISABLE_NS 150
`define SYNC_STAGES 2
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC `CYC(`ADDR_SETUP_NS)
`define HIGH_CYC `CYC(`MIN_SELECT_HIGH_TIME_NS)
`define LOW_CYC `CYC(`SELECT_LOW_NS)
`define CYCLE_CYC `CYC(`CYCLE_NS)
`define STROBE_CYC `CYC(`STROBE_LOW_NS)
`define WR_LOW_CYC `CYC(`STROBE_HOLD_NS)
`define HOLD_CYC `CYC(`WRITE_DATA_HOLD_NS)
`define AVALID_CYC `CYC(`DECODER_ADDRESS_VALID_TIME_NS)
`define RD_LOW_CYC (`CYC(`ACCESS_NS) + `SYNC_STAGES)
`define RECOVER_CYC `CYC(`OUT_DISABLE_NS)

`endif

// file: core/ram_host_pkg.sv
// types for the latched-address ram host
package ram_host_pkg;
  typedef struct packed {
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } req_t;

  typedef struct packed {
    logic [13:0] addr;
    logic sel_a;
    logic sel_b;
    logic write_n;
    logic oe_a_n;
    logic oe_b_n;
    logic [15:0] dq_out;
    logic dq_oe;
  } pin_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_ACT = 5'b00100,
    ST_WEND = 5'b01000,
    ST_REC = 5'b10000
  } state_t;
endpackage

// file: core/ram_host.sv
// host controller driving the latched-address ram module pins
`timescale 1ns/10ps
`include "ram_host_defines.svh"

module ram_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user request and answer
  input wire logic org_wide,
  input wire logic req_valid,
  input wire ram_host_pkg::req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // module pins
  output logic [13:0] mem_addr,
  output logic bank_a_select_low_one,
  output logic bank_a_select_low_two,
  output logic bank_a_select_high,
  output logic bank_b_select_low_one,
  output logic bank_b_select_low_two,
  output logic bank_b_select_high,
  output logic bank_a_output_enable_n,
  output logic bank_b_output_enable_n,
  output logic write_n,
  input wire logic [7:0] dq_a_in,
  output logic [7:0] dq_a_out,
  output logic dq_a_oe,
  input wire logic [7:0] dq_b_in,
  output logic [7:0] dq_b_out,
  output logic dq_b_oe
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  ram_host_pkg::state_t state_r, state_nxt;
  ram_host_pkg::pin_t pin_r, pin_nxt;
  ram_host_pkg::req_t cur_r, cur_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [15:0] rsp_data_r, rsp_data_nxt;
  logic [15:0] dq_s1_r, dq_s2_r;
  logic use_a, use_b;
  logic [7:0] rd_byte;

  // bank choice: wide mode both, byte mode by top address bit
  // bank steering
  assign use_a = org_wide | ~cur_r.addr[`BANK_SEL_BIT];
  assign use_b = org_wide | cur_r.addr[`BANK_SEL_BIT];
  assign rd_byte = cur_r.addr[`BANK_SEL_BIT] ? dq_s2_r[15:8] : dq_s2_r[7:0];

  // sequence of one access
  always_comb
  begin
    state_nxt = state_r;
    pin_nxt = pin_r;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r + 5'd1;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    case (state_r)
      ram_host_pkg::ST_IDLE:
      begin
        cnt_nxt = 5'd0;
        if (req_valid)
        begin
          cur_nxt = req;
          pin_nxt.addr = req.addr[13:0];
          pin_nxt.dq_out = org_wide ? req.wdata : {req.wdata[7:0], req.wdata[7:0]};
          pin_nxt.dq_oe = req.we;
          state_nxt = ram_host_pkg::ST_SETUP;
        end
      end
      ram_host_pkg::ST_SETUP:
      begin
        if (cnt_r == 5'(`SETUP_CYC - 1))
        begin
          // strobe falls with select in a write, output enable falls with it in a read
          pin_nxt.sel_a = use_a;
          pin_nxt.sel_b = use_b;
          pin_nxt.write_n = ~cur_r.we;
          pin_nxt.oe_a_n = cur_r.we | ~use_a;
          pin_nxt.oe_b_n = cur_r.we | ~use_b;
          cnt_nxt = 5'd0;
          state_nxt = ram_host_pkg::ST_ACT;
        end
      end
      ram_host_pkg::ST_ACT:
      begin
        if (cur_r.we && cnt_r == 5'(`WR_LOW_CYC - 1))
        begin
          // strobe rises first, data held four cycles past its edge
          pin_nxt.write_n = 1'b1;
          cnt_nxt = 5'd0;
          state_nxt = ram_host_pkg::ST_WEND;
        end
        else if (!cur_r.we && cnt_r == 5'(`RD_LOW_CYC - 1))
        begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = org_wide ? dq_s2_r : {8'h00, rd_byte};
          pin_nxt.sel_a = 1'b0;
          pin_nxt.sel_b = 1'b0;
          pin_nxt.oe_a_n = 1'b1;
          pin_nxt.oe_b_n = 1'b1;
          cnt_nxt = 5'd0;
          state_nxt = ram_host_pkg::ST_REC;
        end
      end
      ram_host_pkg::ST_WEND:
      begin
        if (cnt_r == 5'(`HOLD_CYC - 1))
        begin
          pin_nxt.sel_a = 1'b0;
          pin_nxt.sel_b = 1'b0;
          pin_nxt.dq_oe = 1'b0;
          cnt_nxt = 5'd0;
          state_nxt = ram_host_pkg::ST_REC;
        end
      end
      ram_host_pkg::ST_REC:
      begin
        // selects stay high before next fall
        if (cnt_r == 5'(`RECOVER_CYC - 1))
        begin
          state_nxt = ram_host_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ram_host_pkg::ST_IDLE;
      end
    endcase
  end

  // registers and data pin synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ram_host_pkg::ST_IDLE;
      pin_r <= '{addr: 14'h0000, sel_a: 1'b0, sel_b: 1'b0, write_n: 1'b1, oe_a_n: 1'b1,
                 oe_b_n: 1'b1, dq_out: 16'h0000, dq_oe: 1'b0};
      cur_r <= '0;
      cnt_r <= 5'd0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      pin_r <= pin_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      dq_s1_r <= {dq_b_in, dq_a_in};
      dq_s2_r <= dq_s1_r;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // third select active high
  assign bank_a_select_low_one = ~pin_r.sel_a;
  assign bank_a_select_low_two = ~pin_r.sel_a;
  assign bank_a_select_high = pin_r.sel_a;
  assign bank_b_select_low_one = ~pin_r.sel_b;
  assign bank_b_select_low_two = ~pin_r.sel_b;
  assign bank_b_select_high = pin_r.sel_b;
  assign bank_a_output_enable_n = pin_r.oe_a_n;
  assign bank_b_output_enable_n = pin_r.oe_b_n;
  assign write_n = pin_r.write_n;
  assign mem_addr = pin_r.addr;
  assign dq_a_out = pin_r.dq_out[7:0];
  assign dq_b_out = pin_r.dq_out[15:8];
  assign dq_a_oe = pin_r.dq_oe & use_a;
  assign dq_b_oe = pin_r.dq_oe & use_b;
  assign req_ready = (state_r == ram_host_pkg::ST_IDLE);
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  logic any_low;
  logic [4:0] lo_cnt_r, hi_cnt_r, fall_cnt_r, wl_cnt_r, av_cnt_r;
  logic [13:0] prev_addr_r;
  assign any_low = pin_r.sel_a | pin_r.sel_b;

  // saturating pin timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo_cnt_r <= 5'd0;
      hi_cnt_r <= 5'd31;
      fall_cnt_r <= 5'd31;
      wl_cnt_r <= 5'd0;
      av_cnt_r <= 5'd0;
      prev_addr_r <= 14'h0000;
    end
    else
    begin
      lo_cnt_r <= any_low ? lo_cnt_r + {4'h0, lo_cnt_r != 5'd31} : 5'd0;
      hi_cnt_r <= !any_low ? hi_cnt_r + {4'h0, hi_cnt_r != 5'd31} : 5'd0;
      fall_cnt_r <= (any_low && lo_cnt_r == 5'd0) ? 5'd1 : fall_cnt_r + {4'h0, fall_cnt_r != 5'd31};
      wl_cnt_r <= !write_n ? wl_cnt_r + {4'h0, wl_cnt_r != 5'd31} : 5'd0;
      av_cnt_r <= (mem_addr == prev_addr_r) ? av_cnt_r + {4'h0, av_cnt_r != 5'd31} : 5'd0;
      prev_addr_r <= mem_addr;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_READ_STROBE_HIGH: assert property (any_low && !(bank_a_output_enable_n && bank_b_output_enable_n) |-> write_n)
    else $error("write strobe low during read");
  AST_WRITE_OE_HIGH: assert property (!write_n |-> bank_a_output_enable_n && bank_b_output_enable_n)
    else $error("output enable low during write");
  AST_NO_READ_BEFORE_STROBE: assert property ($rose(any_low) && cur_r.we |-> !write_n)
    else $error("select fell before strobe in write");
  AST_HIGH_TIME: assert property ($rose(any_low) |-> hi_cnt_r >= 5'(`HIGH_CYC))
    else $error("select high time too short");
  AST_ADDR_STABLE: assert property (any_low |-> $stable(mem_addr))
    else $error("address moved while selected");
  AST_ONE_BANK: assert property (!org_wide |-> !(pin_r.sel_a && pin_r.sel_b))
    else $error("two banks selected in byte mode");
  AST_DECODE_VALID: assert property ($fell(any_low) |-> av_cnt_r >= 5'(`AVALID_CYC))
    else $error("decoder address not held long enough");
  AST_WIDE_PAIR: assert property (org_wide |-> pin_r.sel_a == pin_r.sel_b)
    else $error("banks differ in wide mode");
  AST_LOW_TIME: assert property ($fell(any_low) |-> lo_cnt_r >= 5'(`LOW_CYC))
    else $error("select low time too short");
  AST_CYCLE_TIME: assert property ($rose(any_low) |-> fall_cnt_r >= 5'(`CYCLE_CYC))
    else $error("select falls too close");
  AST_STROBE_WIDTH: assert property ($rose(write_n) |-> wl_cnt_r >= 5'(`STROBE_CYC) && any_low)
    else $error("strobe pulse too short");
  AST_STROBE_FROM_FALL: assert property ($rose(write_n) |-> $past(lo_cnt_r) >= 5'(`WR_LOW_CYC - 1))
    else $error("strobe released too early");
  AST_DATA_HOLD: assert property ($rose(write_n) |-> (dq_a_oe | dq_b_oe) && $stable(pin_r.dq_out) ##1
                                   ((dq_a_oe | dq_b_oe) && $stable(pin_r.dq_out))[*3])
    else $error("write data hold violated");
  AST_READ_ANSWER: assert property ($rose(any_low) && !cur_r.we |-> ##15 rsp_valid)
    else $error("read answer late");

  COV_WRITE: cover property ($rose(write_n) && any_low);
  COV_READ: cover property (rsp_valid);
  COV_BYTE_B: cover property (!org_wide && pin_r.sel_b);
  COV_WIDE: cover property (org_wide && pin_r.sel_a && pin_r.sel_b);

endmodule

// file: testbench/ram_bank_model.sv
// behavioural model of one bank of the latched-address ram module
`timescale 1ns/10ps

module ram_bank_model (
  // pins from the host
  input wire logic [13:0] addr,
  input wire logic sel_low_one,
  input wire logic sel_low_two,
  input wire logic sel_high,
  input wire logic oe_n,
  input wire logic write_n,
  input wire logic [7:0] host_d,
  input wire logic host_oe,
  // resolved data bus
  output logic [7:0] bus
);
  logic [7:0] mem [0:16383];
  logic [13:0] lat;
  logic [7:0] wd, junk;
  logic sel, wpend, valid, drive;
  assign sel = !sel_low_one && !sel_low_two && sel_high;
  always @(posedge sel)
  begin
    lat = addr;
    valid = 1'b0;
    #250 valid = sel;
  end
  // data taken while select and strobe low
  always @*
  begin
    if (sel && !write_n)
    begin
      wd = host_d;
      wpend = 1'b1;
    end
  end
  // write ends at first rise, block from upper bits
  always @(posedge write_n or negedge sel)
  begin
    if (wpend === 1'b1)
      mem[{lat[13:11], lat[10:0]}] = wd;
    wpend = 1'b0;
  end
  // drive only when selected, enabled, strobe high
  assign drive = sel && !oe_n && write_n;
  assign bus = host_oe ? host_d : (drive ? (valid ? mem[lat] : ~mem[lat]) : junk);
  // released lines change every half clock cycle
  initial
  begin
    junk = 8'h5a;
    wpend = 1'b0;
    valid = 1'b0;
  end
  always #10 junk = ~junk;
endmodule

// file: testbench/ram_host_tb.sv
// self-checking testbench for the latched-address ram host
`timescale 1ns/10ps

module ram_host_tb;
  logic clk, rst_n, org_wide, req_valid, req_ready, rsp_valid, write_n;
  ram_host_pkg::req_t req;
  logic [15:0] rsp_data;
  logic [13:0] mem_addr;
  logic bank_a_select_low_one, bank_a_select_low_two, bank_a_select_high;
  logic bank_b_select_low_one, bank_b_select_low_two, bank_b_select_high;
  logic bank_a_output_enable_n, bank_b_output_enable_n;
  logic [7:0] dq_a_in, dq_a_out, dq_b_in, dq_b_out;
  logic dq_a_oe, dq_b_oe, sel_a, sel_b, any_sel;
  int fails, n_tests, cycles;
  realtime t_rise, t_fall;

  ram_host ram_host_inst (.clk, .rst_n, .org_wide, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
    .mem_addr, .bank_a_select_low_one, .bank_a_select_low_two, .bank_a_select_high,
    .bank_b_select_low_one, .bank_b_select_low_two, .bank_b_select_high, .bank_a_output_enable_n,
    .bank_b_output_enable_n, .write_n, .dq_a_in, .dq_a_out, .dq_a_oe, .dq_b_in, .dq_b_out, .dq_b_oe);
  ram_bank_model bank_a_model (.addr(mem_addr), .sel_low_one(bank_a_select_low_one),
    .sel_low_two(bank_a_select_low_two), .sel_high(bank_a_select_high), .oe_n(bank_a_output_enable_n),
    .write_n(write_n), .host_d(dq_a_out), .host_oe(dq_a_oe), .bus(dq_a_in));
  ram_bank_model bank_b_model (.addr(mem_addr), .sel_low_one(bank_b_select_low_one),
    .sel_low_two(bank_b_select_low_two), .sel_high(bank_b_select_high), .oe_n(bank_b_output_enable_n),
    .write_n(write_n), .host_d(dq_b_out), .host_oe(dq_b_oe), .bus(dq_b_in));

  always #10 clk = ~clk;
  assign sel_a = !bank_a_select_low_one && !bank_a_select_low_two && bank_a_select_high;
  assign sel_b = !bank_b_select_low_one && !bank_b_select_low_two && bank_b_select_high;
  assign any_sel = sel_a || sel_b;

  // ----------------------------------------
  // monitors and shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // select widths and spacing
  always @(any_sel)
  begin
    if (any_sel && rst_n === 1'b1)
    begin
      check("sel_high", 16'(($realtime - t_rise) >= 100.0), 16'h0001);
      check("sel_period", 16'(($realtime - t_fall) >= 350.0), 16'h0001);
      t_fall = $realtime;
    end
    else if (rst_n === 1'b1)
    begin
      check("sel_low", 16'(($realtime - t_fall) >= 250.0), 16'h0001);
      t_rise = $realtime;
    end
  end

  // pin relations every cycle
  always @(negedge clk)
  begin
    if (rst_n)
    begin
      check("two_banks", 16'(sel_a && sel_b && !org_wide), 16'h0000);
      check("wide_pair", 16'((sel_a ^ sel_b) && org_wide), 16'h0000);
      check("read_strobe", 16'(!(bank_a_output_enable_n && bank_b_output_enable_n) && !write_n), 16'h0000);
    end
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic access(input logic we, input logic [14:0] a, input logic [15:0] wd, input logic [15:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n = n + 1;
    end
    while (req_ready !== 1'b1 && n < 40);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{we, a, wd};
    @(posedge clk);
    req_valid <= 1'b0;
    if (!we)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n = n + 1;
      end
      while (rsp_valid !== 1'b1 && n < 30);
      check("rsp_latency", 16'(n), 16'h0011);
      check("rsp_data", rsp_data, exp);
    end
  endtask

  task automatic set_mode(input logic m, input logic [15:0] exp);
    access(1'b0, 15'h0000, 16'h0000, exp);
    repeat (12) @(posedge clk);
    org_wide <= m;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    @(negedge clk);
    check("idle_pins", 16'({bank_a_select_low_one, bank_a_select_low_two, bank_a_select_high,
      bank_b_select_low_one, bank_b_select_low_two, bank_b_select_high, bank_a_output_enable_n,
      bank_b_output_enable_n, write_n, dq_a_oe, dq_b_oe}), 16'h06dc);
    access(1'b1, 15'h0000, 16'h1234, 16'h0000);
    access(1'b0, 15'h0000, 16'h0000, 16'h1234);
  endtask

  task automatic test_wide_blocks();
    for (int b = 0; b < 8; b++)
      access(1'b1, {1'b0, 3'(b), 11'h555}, {8'h5a ^ 8'(b), 8'ha0 + 8'(b)}, 16'h0000);
    access(1'b1, 15'h3d55, 16'hbeef, 16'h0000);
    for (int b = 0; b < 8; b++)
      access(1'b0, {1'b0, 3'(b), 11'h555}, 16'h0000, (b == 7) ? 16'hbeef : {8'h5a ^ 8'(b), 8'ha0 + 8'(b)});
  endtask

  task automatic test_byte_banks();
    set_mode(1'b0, 16'h1234);
    access(1'b1, 15'h0123, 16'h7711, 16'h0000);
    access(1'b1, 15'h4123, 16'h7722, 16'h0000);
    access(1'b1, 15'h7fff, 16'h00ee, 16'h0000);
    access(1'b0, 15'h0123, 16'h0000, 16'h0011);
    access(1'b0, 15'h4123, 16'h0000, 16'h0022);
    access(1'b0, 15'h7fff, 16'h0000, 16'h00ee);
    set_mode(1'b1, 16'h0034);
    access(1'b0, 15'h0123, 16'h0000, 16'h2211);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    org_wide = 1'b1;
    req_valid = 1'b0;
    req = '0;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    t_rise = -1000.0;
    t_fall = -1000.0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_wide_blocks();
    test_byte_banks();
    repeat (40) @(posedge clk);
    conclude();
  end
endmodule
